// >>> inc/acb_regs.vh
/*
  Constants of the accumulator, compare and branch execution block: opcodes,
  dataspace locations of the working registers, ALU functions and operand modes.
  Included by the ALU and the core design files, not by acb_rel_target; holds definitions only.
*/
`ifndef ACB_REGS_VH
`define ACB_REGS_VH

// Opcode bytes of the one-byte and the first byte of the two-byte forms.
`define ACB_OP_INVERT      8'h2D
`define ACB_OP_CMP_IND_X   8'h27
`define ACB_OP_CMP_IND_Y   8'h2F
`define ACB_OP_CMP_DIR     8'h3F
`define ACB_OP_CMP_LIT     8'h37
`define ACB_OP_DEC_IND_X   8'hE7
`define ACB_OP_DEC_IND_Y   8'hEF
`define ACB_OP_DEC_DIR     8'hFF
`define ACB_OP_INC_IND_X   8'h67
`define ACB_OP_INC_IND_Y   8'h6F
`define ACB_OP_INC_DIR     8'h7F

// Field positions inside an opcode byte.
`define ACB_IND_SEL_BIT    3
`define ACB_SHORT_REG_HI   7
`define ACB_SHORT_REG_LO   6
`define ACB_SHORT_DEC_BIT  3
`define ACB_DISP_HI        7
`define ACB_DISP_LO        3
`define ACB_JP_HI_HI       7
`define ACB_JP_HI_LO       4

// Dataspace locations of the accumulator and of the four short registers.
`define ACB_ACC_ADDR       8'hFF
`define ACB_SHORT_BASE     6'h20

`define ACB_RESET_PC       12'h000

// Instruction lengths in cycles.
`define ACB_CYC_LONG       4
`define ACB_CYC_SHORT      2

// ALU functions.
`define ACB_FN_COM         2'h0
`define ACB_FN_CMP         2'h1
`define ACB_FN_INC         2'h2
`define ACB_FN_DEC         2'h3

// Operand addressing modes.
`define ACB_MODE_ACC       3'h0
`define ACB_MODE_IND       3'h1
`define ACB_MODE_DIR       3'h2
`define ACB_MODE_SHORT     3'h3
`define ACB_MODE_LIT       3'h4

`endif

// >>> src/acb_alu.v
/*
  Combinational ALU for complement, compare, increment and decrement.
  Assumes the caller decides which result and which flags are written back.
*/
`timescale 1ns/100ps
`include "acb_regs.vh"

module acb_alu (
  input  wire [1:0] func,      // ALU function code
  input  wire [7:0] accIn,     // accumulator value
  input  wire [7:0] srcIn,     // operand value
  output reg  [7:0] result,    // result byte
  output reg        zeroOut,   // result is zero
  output reg        carryOut   // carry for complement and compare
);

  reg [8:0] diff;

  always @*
  begin
    diff     = {1'b0, accIn} - {1'b0, srcIn};
    result   = 8'h00;
    carryOut = 1'b0;
    case (func)
      `ACB_FN_COM:
      begin
        result   = ~accIn;
        carryOut = accIn[7];
      end
      `ACB_FN_CMP:
      begin
        // The difference only feeds the flags; the borrow means acc < src.
        result   = diff[7:0];
        carryOut = diff[8];
      end
      `ACB_FN_INC:
        result = srcIn + 8'h01;
      default:
        result = srcIn - 8'h01;
    endcase
    zeroOut = (result == 8'h00);
  end

endmodule // acb_alu

// >>> src/acb_rel_target.v
/*
  Target address of a short relative branch.
  Assumes nextPc is the address of the byte after the branch opcode.
*/
`timescale 1ns/100ps

module acb_rel_target (
  input  wire [11:0] nextPc,   // address after the opcode
  input  wire [4:0]  disp,     // signed displacement
  output wire [11:0] target    // branch target
);

  // The 12-bit sum simply wraps at the ends of program space.
  assign target = nextPc + {{7{disp[4]}}, disp};

endmodule // acb_rel_target

// >>> src/acb_core.v
/*
  Execution of complement, compare, increment, decrement, absolute jump and
  carry-conditioned short jumps for an 8-bit core slice.
  Assumes program memory and external dataspace answer combinationally within
  the cycle in which the address is presented, and that both are synchronous
  to core_clk.
*/
`timescale 1ns/100ps
`include "acb_regs.vh"

// Function
// - Complement inverts accumulator; one byte, four cycles
// - Complement: zero from result, carry from old MSB
// - Compare leaves accumulator and source unchanged
// - Compare: zero if equal, carry if acc below
// - Indirect and direct compare forms, four cycles
// - Literal compare: opcode plus byte, four cycles
// - Step down destination; zero updated, carry kept
// - Step up destination; zero updated, carry kept
// - Absolute jump loads 12-bit target, flags kept
// - Absolute jump stacks nothing, old address lost
// - Carry set: add signed displacement, two cycles
// - Carry clear: add displacement, two cycles
module acb_core (
  input  wire        core_clk,   // core clock, 100 MHz
  input  wire        rst_n,      // asynchronous reset, active low
  output wire [11:0] progAddr,   // program memory address
  input  wire [7:0]  progData,   // program memory byte at progAddr
  output wire [7:0]  dsRdAddr,   // dataspace read address
  output wire        dsRdEn,     // dataspace read strobe
  input  wire [7:0]  dsRdData,   // dataspace read data
  output wire [7:0]  dsWrAddr,   // dataspace write address
  output wire [7:0]  dsWrData,   // dataspace write data
  output wire        dsWrEn,     // dataspace write strobe
  output wire [7:0]  accOut,     // accumulator
  output wire        zeroFlag,   // zero flag
  output wire        carryFlag,  // carry flag
  output wire [11:0] pcOut,      // program counter
  output wire        instrDone,  // last cycle of an instruction just ended
  output wire        unknownOp   // skipped an opcode outside this slice
);

  localparam [3:0] ST_FETCH = 4'h1;
  localparam [3:0] ST_BYTE2 = 4'h2;
  localparam [3:0] ST_READ  = 4'h4;
  localparam [3:0] ST_EXEC  = 4'h8;

  reg  [3:0]  state_q;
  reg  [3:0]  state_d;
  reg  [11:0] pc_q;
  reg  [7:0]  opcode_q;
  reg  [7:0]  byte2_q;
  reg  [7:0]  operand_q;
  reg  [7:0]  target_q;
  reg  [7:0]  acc_q;
  reg  [7:0]  shortReg_q [0:3];
  reg         zero_q;
  reg         carry_q;
  reg  [7:0]  wrAddr_q;
  reg  [7:0]  wrData_q;
  reg         wrEn_q;
  reg         done_q;
  reg         unknown_q;
  integer     i;

  reg         dIsCom;
  reg         dIsCmp;
  reg         dIsInc;
  reg         dIsDec;
  reg         dIsJp;
  reg         dIsJrc;
  reg         dIsJrnc;
  reg         dTwoByte;
  reg         dKnown;
  reg  [2:0]  dMode;
  reg  [7:0]  opAddr;
  reg  [7:0]  opValue;
  reg  [1:0]  aluFunc;
  reg  [11:0] pcNext;

  wire        stFetch = state_q[0];
  wire        stByte2 = state_q[1];
  wire        stRead  = state_q[2];
  wire        stExec  = state_q[3];
  wire [7:0]  curOp   = stFetch ? progData : opcode_q;
  wire [11:0] pcPlus1 = pc_q + 12'h001;
  wire [11:0] pcPlus2 = pc_q + 12'h002;
  wire [7:0]  aluRes;
  wire        aluZero;
  wire        aluCarry;
  wire [11:0] relTarget;
  wire        tgtIsAcc   = (target_q == `ACB_ACC_ADDR);
  wire        tgtIsShort = (target_q[7:2] == `ACB_SHORT_BASE);
  wire        relTaken   = (dIsJrc & carry_q) | (dIsJrnc & ~carry_q);

  // Instruction decode; one-byte forms that do not belong here are skipped.
  always @*
  begin
    dIsCom   = 1'b0;
    dIsCmp   = 1'b0;
    dIsInc   = 1'b0;
    dIsDec   = 1'b0;
    dIsJp    = 1'b0;
    dIsJrc   = 1'b0;
    dIsJrnc  = 1'b0;
    dTwoByte = 1'b0;
    dKnown   = 1'b1;
    dMode    = `ACB_MODE_ACC;
    casez (curOp)
      `ACB_OP_INVERT:
        dIsCom = 1'b1;
      `ACB_OP_CMP_IND_X, `ACB_OP_CMP_IND_Y:
      begin
        dIsCmp = 1'b1;
        dMode  = `ACB_MODE_IND;
      end
      `ACB_OP_CMP_DIR:
      begin
        dIsCmp   = 1'b1;
        dMode    = `ACB_MODE_DIR;
        dTwoByte = 1'b1;
      end
      `ACB_OP_CMP_LIT:
      begin
        dIsCmp   = 1'b1;
        dMode    = `ACB_MODE_LIT;
        dTwoByte = 1'b1;
      end
      `ACB_OP_DEC_IND_X, `ACB_OP_DEC_IND_Y:
      begin
        dIsDec = 1'b1;
        dMode  = `ACB_MODE_IND;
      end
      `ACB_OP_DEC_DIR:
      begin
        dIsDec   = 1'b1;
        dMode    = `ACB_MODE_DIR;
        dTwoByte = 1'b1;
      end
      `ACB_OP_INC_IND_X, `ACB_OP_INC_IND_Y:
      begin
        dIsInc = 1'b1;
        dMode  = `ACB_MODE_IND;
      end
      `ACB_OP_INC_DIR:
      begin
        dIsInc   = 1'b1;
        dMode    = `ACB_MODE_DIR;
        dTwoByte = 1'b1;
      end
      8'b??01_?101:
      begin
        dIsDec = curOp[`ACB_SHORT_DEC_BIT];
        dIsInc = ~curOp[`ACB_SHORT_DEC_BIT];
        dMode  = `ACB_MODE_SHORT;
      end
      8'b????_1001:
      begin
        dIsJp    = 1'b1;
        dTwoByte = 1'b1;
      end
      8'b????_?110:
        dIsJrc = 1'b1;
      8'b????_?010:
        dIsJrnc = 1'b1;
      default:
        dKnown = 1'b0;
    endcase
  end

  // Operand location and value, valid in the read cycle.
  always @*
  begin
    case (dMode)
      `ACB_MODE_IND:
        opAddr = shortReg_q[{1'b0, opcode_q[`ACB_IND_SEL_BIT]}];
      `ACB_MODE_DIR:
        opAddr = byte2_q;
      `ACB_MODE_SHORT:
        opAddr = {`ACB_SHORT_BASE, opcode_q[`ACB_SHORT_REG_HI:`ACB_SHORT_REG_LO]};
      default:
        opAddr = `ACB_ACC_ADDR;
    endcase
    if (dMode == `ACB_MODE_LIT)
      opValue = byte2_q;
    else if (opAddr == `ACB_ACC_ADDR)
      opValue = acc_q;
    else if (opAddr[7:2] == `ACB_SHORT_BASE)
      opValue = shortReg_q[opAddr[1:0]];
    else
      opValue = dsRdData;
  end

  always @*
  begin
    if (dIsCom)
      aluFunc = `ACB_FN_COM;
    else if (dIsCmp)
      aluFunc = `ACB_FN_CMP;
    else if (dIsInc)
      aluFunc = `ACB_FN_INC;
    else
      aluFunc = `ACB_FN_DEC;
  end

  acb_alu uAlu (
    .func     (aluFunc),
    .accIn    (acc_q),
    .srcIn    (operand_q),
    .result   (aluRes),
    .zeroOut  (aluZero),
    .carryOut (aluCarry)
  );

  acb_rel_target uRel (
    .nextPc (pcPlus1),
    .disp   (opcode_q[`ACB_DISP_HI:`ACB_DISP_LO]),
    .target (relTarget)
  );

  // Address after the instruction; the jump overwrites it without stacking.
  always @*
  begin
    if (dIsJp)
      pcNext = {opcode_q[`ACB_JP_HI_HI:`ACB_JP_HI_LO], byte2_q};
    else if (relTaken)
      pcNext = relTarget;
    else if (dTwoByte)
      pcNext = pcPlus2;
    else
      pcNext = pcPlus1;
  end

  // Short branches and skipped opcodes finish in two cycles, the rest in four.
  always @*
  begin
    case (state_q)
      ST_FETCH:
        if (dIsJrc || dIsJrnc || !dKnown)
          state_d = ST_EXEC;
        else
          state_d = ST_BYTE2;
      ST_BYTE2:
        state_d = ST_READ;
      ST_READ:
        state_d = ST_EXEC;
      ST_EXEC:
        state_d = ST_FETCH;
      default:
        state_d = ST_FETCH;
    endcase
  end

  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q   <= ST_FETCH;
      pc_q      <= `ACB_RESET_PC;
      opcode_q  <= 8'h00;
      byte2_q   <= 8'h00;
      operand_q <= 8'h00;
      target_q  <= 8'h00;
      acc_q     <= 8'h00;
      zero_q    <= 1'b0;
      carry_q   <= 1'b0;
      wrAddr_q  <= 8'h00;
      wrData_q  <= 8'h00;
      wrEn_q    <= 1'b0;
      done_q    <= 1'b0;
      unknown_q <= 1'b0;
      for (i = 0; i < 4; i = i + 1)
        shortReg_q[i] <= 8'h00;
    end
    else
    begin
      state_q   <= state_d;
      wrEn_q    <= 1'b0;
      done_q    <= stExec;
      unknown_q <= stExec & ~dKnown;
      if (stFetch)
        opcode_q <= progData;
      if (stByte2)
        byte2_q <= progData;
      if (stRead)
      begin
        operand_q <= opValue;
        target_q  <= opAddr;
      end
      if (stExec)
      begin
        pc_q <= pcNext;
        if (dIsCom)
        begin
          acc_q   <= aluRes;
          zero_q  <= aluZero;
          carry_q <= aluCarry;
        end
        if (dIsCmp)
        begin
          zero_q  <= aluZero;
          carry_q <= aluCarry;
        end
        // Carry is left alone here on purpose.
        if (dIsInc || dIsDec)
        begin
          zero_q <= aluZero;
          if (tgtIsAcc)
            acc_q <= aluRes;
          else if (tgtIsShort)
            shortReg_q[target_q[1:0]] <= aluRes;
          else
          begin
            // The write lands in the next cycle, before any later read.
            wrEn_q   <= 1'b1;
            wrAddr_q <= target_q;
            wrData_q <= aluRes;
          end
        end
      end
    end
  end

  assign progAddr  = stByte2 ? pcPlus1 : pc_q;
  assign dsRdAddr  = opAddr;
  assign dsRdEn    = stRead & (dMode == `ACB_MODE_IND || dMode == `ACB_MODE_DIR)
                     & (opAddr != `ACB_ACC_ADDR) & (opAddr[7:2] != `ACB_SHORT_BASE);
  assign dsWrAddr  = wrAddr_q;
  assign dsWrData  = wrData_q;
  assign dsWrEn    = wrEn_q;
  assign accOut    = acc_q;
  assign zeroFlag  = zero_q;
  assign carryFlag = carry_q;
  assign pcOut     = pc_q;
  assign instrDone = done_q;
  assign unknownOp = unknown_q;

endmodule // acb_core

// >>> verification/acb_core_props.sv
/*
  Port-level assertions for acb_core: strobe timing, flags and branch targets.
  Assumes it is bound to acb_core and watches only that module's ports.
*/
`timescale 1ns/100ps

module acb_core_props (
  input wire        core_clk,   // core clock
  input wire        rst_n,      // reset, active low
  input wire [7:0]  progData,   // program byte
  input wire        dsRdEn,     // read strobe
  input wire        dsWrEn,     // write strobe
  input wire [7:0]  accOut,     // accumulator
  input wire        zeroFlag,   // zero flag
  input wire        carryFlag,  // carry flag
  input wire [11:0] pcOut,      // program counter
  input wire        instrDone   // instruction end pulse
);
  // The opcode leaves progData once progAddr moves past the fetch cycle, so checks at the instruction end need a copy.
  reg  [7:0]  opHold_q;
  wire [11:0] dispExt = {{7{opHold_q[7]}}, opHold_q[7:3]};

  always @(posedge core_clk or negedge rst_n)
    if (!rst_n)
      opHold_q <= 8'h00;
    else if (instrDone)
      opHold_q <= progData;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  AST_WR_WITH_DONE: assert property (dsWrEn |-> instrDone ##1 !dsWrEn)
    else $error("Write strobe not a single pulse at instruction end");
  AST_RD_SLOT: assert property (dsRdEn |=> !dsRdEn ##1 instrDone)
    else $error("Operand read not two cycles before instruction end");
  AST_COM_RESULT: assert property (instrDone && progData == 8'h2D |-> ##4 instrDone
    && accOut == ~$past(accOut, 4) && carryFlag == ~accOut[7] && zeroFlag == (accOut == 8'h00))
    else $error("Complement result or flags wrong");
  AST_CMP_KEEP: assert property (instrDone && progData inside {8'h27, 8'h2F, 8'h3F, 8'h37}
    |=> (!dsWrEn && $stable(accOut)) [*4])
    else $error("Compare changed the accumulator or wrote data");
  AST_CMP_LIT: assert property (instrDone && progData == 8'h37 |-> ##4 instrDone
    && zeroFlag == (accOut == $past(progData, 3)) && carryFlag == (accOut < $past(progData, 3)))
    else $error("Literal compare flags wrong");
  AST_STEP_CARRY: assert property (instrDone && ((progData & 8'h37) == 8'h15
    || progData inside {8'h67, 8'h6F, 8'h7F, 8'hE7, 8'hEF, 8'hFF}) |=> $stable(carryFlag) [*4])
    else $error("Increment or decrement changed carry");
  AST_JUMP_ABS: assert property (instrDone && progData[3:0] == 4'h9
    |-> ##1 ($stable(zeroFlag) && $stable(carryFlag)) [*4]
    ##0 (instrDone && pcOut == {opHold_q[7:4], $past(progData, 3)}))
    else $error("Absolute jump target or flags wrong");
  AST_JUMP_REL: assert property (instrDone && progData[1:0] == 2'b10 |-> ##2 instrDone
    && pcOut == $past(pcOut, 2) + 12'h001 + ((opHold_q[2] == carryFlag) ? dispExt : 12'h000)
    && $stable(zeroFlag) && $stable(carryFlag))
    else $error("Short branch target or flags wrong");
endmodule // acb_core_props

bind acb_core acb_core_props props_u (.core_clk, .rst_n, .progData, .dsRdEn, .dsWrEn,
  .accOut, .zeroFlag, .carryFlag, .pcOut, .instrDone);

// >>> verification/acb_core_test.sv
/*
  Self-checking bench for acb_core: random programs checked against an integer model.
  Assumes program and data memories answer in the cycle of the address, as built here.
*/
`timescale 1ns/100ps

module acb_core_test;
  reg         core_clk = 1'b0;
  reg         rst_n    = 1'b0;
  reg  [7:0]  junk     = 8'hA5;
  reg  [7:0]  pm [0:4095];
  reg  [7:0]  dm [0:255];
  wire [11:0] progAddr, pcOut;
  wire [7:0]  progData, dsRdAddr, dsRdData, dsWrAddr, dsWrData, accOut;
  wire        dsRdEn, dsWrEn, zeroFlag, carryFlag, instrDone, unknownOp;
  logic [7:0] opTab [16] = '{8'h2D, 8'h27, 8'h2F, 8'h3F, 8'h37, 8'hE7, 8'hEF, 8'hFF,
                             8'h67, 8'h6F, 8'h7F, 8'h55, 8'h9D, 8'h49, 8'h36, 8'hAA};
  int md[256], sr[4], acc, z, c, pc, cy, unk, ewr, ewa, ewd, erd, k, run;
  int rdGot = -1;
  int bad_count = 0;
  int check_count = 0;

  always #5 core_clk = ~core_clk;

  // A released read bus shows a toggling pattern, so a late sample cannot match by luck.
  assign progData = pm[progAddr];
  assign dsRdData = dsRdEn ? dm[dsRdAddr] : junk;

  always @(posedge core_clk)
  begin
    junk <= ~junk;
    if (dsWrEn === 1'b1)
      dm[dsWrAddr] <= dsWrData;
    if (dsRdEn === 1'b1)
      rdGot = dsRdAddr;
  end

  acb_core dut_u (.core_clk, .rst_n, .progAddr, .progData, .dsRdAddr, .dsRdEn, .dsRdData,
    .dsWrAddr, .dsWrData, .dsWrEn, .accOut, .zeroFlag, .carryFlag, .pcOut, .instrDone,
    .unknownOp);

  function automatic int rd(int a);
    if (a == 255)
      return acc;
    if (a >= 128 && a < 132)
      return sr[a - 128];
    erd = a;
    return md[a];
  endfunction

  task automatic wr(int a, int v);
    ewr = (a != 255) && (a < 128 || a > 131);
    ewa = a;
    ewd = v;
    if (a == 255)
      acc = v;
    else if (!ewr)
      sr[a - 128] = v;
    else
      md[a] = v;
  endtask

  task automatic step_mem(int a, int d);
    int v;
    v = (rd(a) + d) & 255;
    z = (v == 0);
    wr(a, v);
  endtask

  task automatic cmp(int s);
    z = (acc == s);
    c = (acc < s);
  endtask

  task automatic short_op(int op);
    cy = 2;
    unk = ((op & 3) != 2);
    if (!unk && ((op >> 2) & 1) == c)
      pc = (pc + ((op >> 3) ^ 16) - 16) & 4095;
  endtask

  task automatic model_step;
    int op, b2;
    op = pm[pc];
    b2 = pm[(pc + 1) & 4095];
    cy = 4;
    unk = 0;
    ewr = 0;
    erd = -1;
    pc = (pc + ((op inside {'h3F, 'h37, 'h7F, 'hFF}) ? 2 : 1)) & 4095;
    case (op)
      'h2D:
      begin
        c = acc >> 7;
        acc = acc ^ 255;
        z = (acc == 0);
      end
      'h27, 'h2F: cmp(rd(sr[(op >> 3) & 1]));
      'h3F: cmp(rd(b2));
      'h37: cmp(b2);
      'h67, 'h6F: step_mem(sr[(op >> 3) & 1], 1);
      'hE7, 'hEF: step_mem(sr[(op >> 3) & 1], -1);
      'h7F: step_mem(b2, 1);
      'hFF: step_mem(b2, -1);
      default:
        if ((op & 'h37) == 'h15)
          step_mem(128 + (op >> 6), (op & 8) ? -1 : 1);
        else if ((op & 15) == 9)
          pc = (op >> 4) * 256 + b2;
        else
          short_op(op);
    endcase
  endtask

  task automatic chk(logic [31:0] got, logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error at %0t: got %0h, expected %0h", $time, got, exp);
    end
  endtask

  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Each reset brings a fresh program and data image, so a branch loop cannot hold the run.
  task automatic do_reset;
    rst_n = 1'b0;
    foreach (pm[i]) pm[i] = ($urandom % 3 == 0) ? 8'($urandom) : opTab[$urandom % 16];
    foreach (md[i]) md[i] = $urandom & 255;
    foreach (dm[i]) dm[i] = 8'(md[i]);
    sr = '{0, 0, 0, 0};
    {acc, z, c, pc} = 0;
    repeat (6) @(posedge core_clk);
    chk({pcOut, accOut, zeroFlag, carryFlag, dsWrEn, dsRdEn, instrDone}, 0);
    #1 rst_n = 1'b1;
  endtask

  task automatic run_one;
    model_step;
    rdGot = -1;
    k = 0;
    do
    begin
      @(posedge core_clk);
      #1 k++;
    end
    while (instrDone !== 1'b1 && k < 9);
    chk(instrDone, 1);
    if (instrDone !== 1'b1)
      finish_test;
    chk(k, cy);
    chk(pcOut, pc);
    chk(progAddr, pc);
    chk(accOut, acc);
    chk({zeroFlag, carryFlag}, z * 2 + c);
    chk(unknownOp, unk);
    chk(rdGot, erd);
    chk(dsWrEn, ewr);
    if (ewr)
      chk({dsWrAddr, dsWrData}, ewa * 256 + ewd);
  endtask

  initial
  begin
    void'($urandom(96));
    for (run = 0; run < 4; run++)
    begin
      do_reset;
      repeat (300) run_one;
    end
    finish_test;
  end
endmodule // acb_core_test
